// ### rtl/vft_pkg.sv
// constants and types for the video source frame timing generator
// Overview of operation
// - frame rate between 58 and 61 Hz, flagged on o_rate_err but not enforced
// - frame sync high at least one line
// - vertical back porch at least two lines
// - vertical front porch at least one line
// - total vertical blanking at least fourteen lines
// - line sync high at least eight pixels
// - horizontal back porch at least nine pixels
// - horizontal front porch at least eight pixels
// - line total never above 8191 pixels
// - same timing for parallel or serial link
// - signals launched opposite the pixel clock active edge
package vft_pkg;
  // ----------------------------------------
  // system clock and frame rate window
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000; // i_clk_sys rate
  localparam int unsigned RATE_MIN_HZ = 58;
  localparam int unsigned RATE_MAX_HZ = 61;
  // least period rounds up, longest rounds down
  localparam int unsigned FRM_CYC_MIN =
    (CLK_HZ + RATE_MAX_HZ - 1) / RATE_MAX_HZ;
  localparam int unsigned FRM_CYC_MAX = CLK_HZ / RATE_MIN_HZ;
  localparam int FRM_W = 20; // frame period counter width
  localparam logic [FRM_W-1:0] FRM_ONE = 20'h00001;
  localparam logic [FRM_W-1:0] FRM_SAT = 20'hfffff;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int HW = 13; // horizontal counts
  localparam int PW = 12; // porch and sync inputs
  localparam int VW = 12; // vertical inputs
  localparam int VTW = 14; // vertical counts
  localparam int PIX_W = 24; // pixel data bus
  localparam int DIV_W = 8; // pixel clock divider
  localparam int unsigned PCLK_HALF_DEF = 1; // sys cycles per half
  // ----------------------------------------
  // horizontal limits, in pixel clocks
  // ----------------------------------------
  localparam logic [HW-1:0] H_ONE = 13'h0001;
  localparam logic [HW-1:0] H_SYNC_MIN = 13'h0008;
  localparam logic [HW-1:0] H_BP_MIN = 13'h0009;
  localparam logic [HW-1:0] H_FP_MIN = 13'h0008;
  localparam logic [HW-1:0] H_BLANK_MIN = 13'h0040;
  localparam logic [HW-1:0] TOTAL_LINE_PIXELS_MAX = 13'h1fff;
  localparam logic [HW-1:0] H_SAT = 13'h1fff;
  // ----------------------------------------
  // vertical limits, in lines
  // ----------------------------------------
  localparam logic [VTW-1:0] V_ONE = 14'h0001;
  localparam logic [VTW-1:0] V_SYNC_MIN = 14'h0001;
  localparam logic [VTW-1:0] V_BP_MIN = 14'h0002;
  localparam logic [VTW-1:0] V_FP_MIN = 14'h0001;
  localparam logic [VTW-1:0] V_BLANK_MIN = 14'h000e;
  // ----------------------------------------
  // test pattern
  // ----------------------------------------
  localparam int RAMP_W = 8; // ramp bits per colour
  localparam int CHK_BIT = 4; // checker square of 16 pixels
  typedef enum logic [1:0] {
    PAT_SOLID, PAT_HRAMP, PAT_VRAMP, PAT_CHECK
  } vft_pat_e;
  typedef enum logic {ST_IDLE, ST_RUN} vft_state_e;
endpackage

// ### rtl/vft_pclk_div.sv
// pixel clock divider with a launch strobe on each falling edge
module vft_pclk_div #(
  parameter int unsigned HALF = vft_pkg::PCLK_HALF_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  output logic o_pclk,
  output logic o_fall
);
  import vft_pkg::*;
  // ----------------------------------------
  // divider state
  // ----------------------------------------
  localparam logic [DIV_W-1:0] CNT_LAST = DIV_W'(HALF - 1);
  logic [DIV_W-1:0] cnt_r; // sys cycles into this half period
  logic pclk_r; // pixel clock level
  // toggle every HALF system cycles
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
      pclk_r <= 1'b0;
    end else if (cnt_r == CNT_LAST) begin
      cnt_r <= '0;
      pclk_r <= ~pclk_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  // strobe in the cycle whose closing edge drops the clock, so data
  // flops move together with the falling edge, away from the rise
  assign o_fall = pclk_r && (cnt_r == CNT_LAST);
  assign o_pclk = pclk_r;
endmodule

// ### rtl/vft_pattern.sv
// test pattern source for the active picture area
module vft_pattern (
  input wire vft_pkg::vft_pat_e i_mode,
  input wire logic [vft_pkg::PIX_W-1:0] i_color,
  input wire logic [vft_pkg::HW-1:0] i_x,
  input wire logic [vft_pkg::VW-1:0] i_y,
  output logic [vft_pkg::PIX_W-1:0] o_pix
);
  import vft_pkg::*;
  // ----------------------------------------
  // pattern select
  // ----------------------------------------
  // ramps repeat every 256 pixels or lines; grey on all three colours
  always_comb begin
    case (i_mode)
      PAT_SOLID: o_pix = i_color;
      PAT_HRAMP: o_pix = {3{i_x[RAMP_W-1:0]}};
      PAT_VRAMP: o_pix = {3{i_y[RAMP_W-1:0]}};
      PAT_CHECK: o_pix = (i_x[CHK_BIT] ^ i_y[CHK_BIT]) ? i_color : '0;
      default: o_pix = i_color;
    endcase
  end
endmodule

// ### rtl/vft_source_top.sv
// video source: frame timing generator driving the controller input
module vft_source_top #(
  parameter int unsigned FRAME_MIN_CYC = vft_pkg::FRM_CYC_MIN,
  parameter int unsigned FRAME_MAX_CYC = vft_pkg::FRM_CYC_MAX,
  parameter int unsigned PCLK_HALF = vft_pkg::PCLK_HALF_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic [vft_pkg::PW-1:0] i_h_sync,
  input wire logic [vft_pkg::PW-1:0] i_h_back,
  input wire logic [vft_pkg::PW-1:0] i_h_front,
  input wire logic [vft_pkg::HW-1:0] i_h_active,
  input wire logic [vft_pkg::VW-1:0] i_v_sync,
  input wire logic [vft_pkg::VW-1:0] i_v_back,
  input wire logic [vft_pkg::VW-1:0] i_v_front,
  input wire logic [vft_pkg::VW-1:0] i_v_active,
  input wire vft_pkg::vft_pat_e i_pattern,
  input wire logic [vft_pkg::PIX_W-1:0] i_color,
  output logic o_pclk,
  output logic o_frame_sync,
  output logic o_line_sync,
  output logic o_data_enable,
  output logic [vft_pkg::PIX_W-1:0] o_pixel_data,
  output logic o_busy,
  output logic o_rate_err
);
  import vft_pkg::*;
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic adv; // launch strobe, one per pixel
  vft_state_e state_r, state_nxt;
  logic [HW-1:0] hcnt_r, h_nxt; // pixel within line
  logic [VTW-1:0] vcnt_r, v_nxt; // line within frame
  logic load; // take fresh timing at frame start
  // clamped timing from the inputs
  logic [HW-1:0] hsw_c, hbp_c, hfp_c, hact_c, hde_c, htot_c;
  logic [VTW-1:0] vsw_c, vbp_c, vfp_c, vact_c, vde_c, vtot_c;
  // timing in force for the current frame
  logic [HW-1:0] hsw_r, hbp_r, hde_r, htot_r;
  logic [VTW-1:0] vsw_r, vbp_r, vde_r, vtot_r;
  logic [HW-1:0] hsw_s, hbp_s, hde_s;
  logic [VTW-1:0] vsw_s, vbp_s, vde_s;
  logic ls_nxt, fs_nxt, de_nxt;
  logic ls_r, fs_r, de_r, busy_r, rate_err_r;
  logic [PIX_W-1:0] pix_c, pix_r;
  logic [HW-1:0] pat_x;
  logic [VTW-1:0] pat_y;
  logic frm_start; // first pixel of a frame launched
  logic [FRM_W-1:0] frm_cyc_r; // sys cycles since last frame start
  logic frm_seen_r; // a previous start exists to measure from

  // ----------------------------------------
  // pixel clock and pattern
  // ----------------------------------------
  vft_pclk_div #(.HALF(PCLK_HALF)) u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .o_pclk(o_pclk),
    .o_fall(adv)
  );

  vft_pattern u_pat (
    .i_mode(i_pattern),
    .i_color(i_color),
    .i_x(pat_x),
    .i_y(pat_y[VW-1:0]),
    .o_pix(pix_c)
  );

  // ----------------------------------------
  // clamp requested timing to the limits
  // ----------------------------------------
  // out-of-range requests are stretched or cut, never refused, so the link
  // always sees a legal frame; the sync shrinks to fit its porch
  always_comb begin
    hsw_c = HW'(i_h_sync);
    if (hsw_c < H_SYNC_MIN) hsw_c = H_SYNC_MIN;
    hbp_c = HW'(i_h_back);
    if (hbp_c < H_BP_MIN) hbp_c = H_BP_MIN;
    if (hsw_c >= hbp_c) hsw_c = hbp_c - H_ONE;
    hfp_c = HW'(i_h_front);
    if (hfp_c < H_FP_MIN) hfp_c = H_FP_MIN;
    if (hbp_c + hfp_c < H_BLANK_MIN) hfp_c = H_BLANK_MIN - hbp_c;
    hact_c = i_h_active;
    if (hact_c == '0) hact_c = H_ONE;
    if (hact_c > TOTAL_LINE_PIXELS_MAX - hbp_c - hfp_c) begin
      hact_c = TOTAL_LINE_PIXELS_MAX - hbp_c - hfp_c;
    end
    hde_c = hbp_c + hact_c;
    htot_c = hde_c + hfp_c;
    vsw_c = VTW'(i_v_sync);
    if (vsw_c < V_SYNC_MIN) vsw_c = V_SYNC_MIN;
    vbp_c = VTW'(i_v_back);
    if (vbp_c < V_BP_MIN) vbp_c = V_BP_MIN;
    if (vsw_c >= vbp_c) vsw_c = vbp_c - V_ONE;
    vfp_c = VTW'(i_v_front);
    if (vfp_c < V_FP_MIN) vfp_c = V_FP_MIN;
    if (vbp_c + vfp_c < V_BLANK_MIN) begin
      vfp_c = V_BLANK_MIN - vbp_c;
    end
    vact_c = VTW'(i_v_active);
    if (vact_c == '0) vact_c = V_ONE;
    vde_c = vbp_c + vact_c;
    vtot_c = vde_c + vfp_c;
  end

  // ----------------------------------------
  // position sequencer
  // ----------------------------------------
  // lines advance only on line wrap: vertical time is whole lines
  always_comb begin
    state_nxt = state_r;
    h_nxt = hcnt_r;
    v_nxt = vcnt_r;
    load = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (i_enable) begin
          state_nxt = ST_RUN;
          h_nxt = '0;
          v_nxt = '0;
          load = 1'b1;
        end
      end
      ST_RUN: begin
        if (hcnt_r == htot_r - H_ONE) begin
          h_nxt = '0;
          if (vcnt_r == vtot_r - V_ONE) begin
            v_nxt = '0;
            load = 1'b1;
            // a drop of enable waits for the frame to finish
            if (!i_enable) state_nxt = ST_IDLE;
          end else begin
            v_nxt = vcnt_r + V_ONE;
          end
        end else begin
          h_nxt = hcnt_r + H_ONE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // decode the next pixel's sync levels
  // ----------------------------------------
  // a new frame decodes with the freshly clamped timing
  always_comb begin
    hsw_s = load ? hsw_c : hsw_r;
    hbp_s = load ? hbp_c : hbp_r;
    hde_s = load ? hde_c : hde_r;
    vsw_s = load ? vsw_c : vsw_r;
    vbp_s = load ? vbp_c : vbp_r;
    vde_s = load ? vde_c : vde_r;
    ls_nxt = (state_nxt == ST_RUN) && (h_nxt < hsw_s);
    fs_nxt = (state_nxt == ST_RUN) && (v_nxt < vsw_s);
    de_nxt = (state_nxt == ST_RUN) && (h_nxt >= hbp_s) &&
      (h_nxt < hde_s) && (v_nxt >= vbp_s) && (v_nxt < vde_s);
    pat_x = h_nxt - hbp_s;
    pat_y = v_nxt - vbp_s;
  end

  assign frm_start = adv && load && (state_nxt == ST_RUN);

  // ----------------------------------------
  // sequencer state, moved on each launch strobe
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      hcnt_r <= '0;
      vcnt_r <= '0;
    end else if (adv) begin
      state_r <= state_nxt;
      hcnt_r <= h_nxt;
      vcnt_r <= v_nxt;
    end
  end

  // ----------------------------------------
  // frame timing shadow
  // ----------------------------------------
  // inputs may change at any time; a frame keeps one geometry
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hsw_r <= H_SYNC_MIN;
      hbp_r <= H_BP_MIN;
      hde_r <= H_BP_MIN;
      htot_r <= H_BLANK_MIN;
      vsw_r <= V_SYNC_MIN;
      vbp_r <= V_BP_MIN;
      vde_r <= V_BP_MIN;
      vtot_r <= V_BLANK_MIN;
    end else if (adv && load) begin
      hsw_r <= hsw_c;
      hbp_r <= hbp_c;
      hde_r <= hde_c;
      htot_r <= htot_c;
      vsw_r <= vsw_c;
      vbp_r <= vbp_c;
      vde_r <= vde_c;
      vtot_r <= vtot_c;
    end
  end

  // ----------------------------------------
  // link outputs
  // ----------------------------------------
  // all launched with the pixel clock fall so the receiver samples
  // on the rise; one set of pins serves the parallel port or a
  // serial transmitter alike
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ls_r <= 1'b0;
      fs_r <= 1'b0;
      de_r <= 1'b0;
      pix_r <= '0;
      busy_r <= 1'b0;
    end else if (adv) begin
      ls_r <= ls_nxt;
      fs_r <= fs_nxt;
      de_r <= de_nxt;
      pix_r <= de_nxt ? pix_c : '0;
      busy_r <= (state_nxt == ST_RUN);
    end
  end

  // ----------------------------------------
  // frame rate monitor
  // ----------------------------------------
  // the verdict is the source's own check of its settings; the
  // pixel clock and geometry set the rate, so software must fix it
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frm_cyc_r <= FRM_ONE;
      frm_seen_r <= 1'b0;
      rate_err_r <= 1'b0;
    end else if (frm_start) begin
      frm_cyc_r <= FRM_ONE;
      frm_seen_r <= 1'b1;
      if (frm_seen_r) begin
        rate_err_r <= (frm_cyc_r < FRM_W'(FRAME_MIN_CYC)) ||
          (frm_cyc_r > FRM_W'(FRAME_MAX_CYC));
      end
    end else begin
      if (frm_cyc_r != FRM_SAT) frm_cyc_r <= frm_cyc_r + FRM_ONE;
      if (state_r == ST_IDLE) frm_seen_r <= 1'b0;
    end
  end

  assign o_line_sync = ls_r;
  assign o_frame_sync = fs_r;
  assign o_data_enable = de_r;
  assign o_pixel_data = pix_r;
  assign o_busy = busy_r;
  assign o_rate_err = rate_err_r;

  // ----------------------------------------
  // checking helpers, counted in pixels and lines
  // ----------------------------------------
  logic [HW-1:0] hs_run_r, since_hs_r, since_de_r;
  logic [VTW-1:0] vs_lines_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hs_run_r <= '0;
      since_hs_r <= '0;
      // no enable has fallen yet: the first line sync after reset must
      // not read as a short front porch
      since_de_r <= H_SAT;
      vs_lines_r <= '0;
    end else if (adv) begin
      hs_run_r <= ls_r ? hs_run_r + H_ONE : '0;
      if (ls_nxt && !ls_r) since_hs_r <= '0;
      else if (since_hs_r != H_SAT) since_hs_r <= since_hs_r + H_ONE;
      if (de_r && !de_nxt) since_de_r <= '0;
      else if (since_de_r != H_SAT) since_de_r <= since_de_r + H_ONE;
      if (ls_nxt && !ls_r && fs_nxt) begin
        vs_lines_r <= fs_r ? vs_lines_r + V_ONE : V_ONE;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_launch;
    $fell(o_pclk);
  endsequence
  sequence s_line_lead;
    $rose(o_line_sync);
  endsequence
  property p_frame_align;
    $rose(o_frame_sync) |-> s_line_lead;
  endproperty

  a_pclk_launch: assert property ($changed(o_line_sync) ||
    $changed(o_data_enable) |-> s_launch)
    else $error("sync or enable moved off the pixel clock fall");
  a_hsync_width: assert property ($fell(o_line_sync) |->
    hs_run_r >= H_SYNC_MIN)
    else $error("line sync shorter than minimum");
  a_hbp_min: assert property ($rose(o_data_enable) |->
    since_hs_r >= H_BP_MIN)
    else $error("horizontal back porch too short");
  a_hfp_min: assert property ($rose(o_line_sync) |->
    since_de_r >= H_FP_MIN)
    else $error("horizontal front porch too short");
  a_line_total: assert property ($rose(o_line_sync) &&
    $past(o_busy) |-> $past(since_hs_r) < TOTAL_LINE_PIXELS_MAX)
    else $error("line longer than the pixel limit");
  a_vsync_lines: assert property ($fell(o_frame_sync) |->
    vs_lines_r >= V_SYNC_MIN)
    else $error("frame sync shorter than one line");
  a_vbp_min: assert property (o_busy |-> vbp_r >= V_BP_MIN &&
    vsw_r < vbp_r)
    else $error("vertical back porch too short");
  a_vfp_min: assert property (o_busy |->
    vtot_r - vde_r >= V_FP_MIN)
    else $error("vertical front porch too short");
  a_vblank_min: assert property (o_busy |->
    vtot_r - vde_r + vbp_r >= V_BLANK_MIN)
    else $error("vertical blanking too short");
  a_frame_align: assert property (p_frame_align)
    else $error("frame sync not on a line start");
  a_rate_flag: assert property (frm_start && frm_seen_r &&
    frm_cyc_r > FRM_W'(FRAME_MAX_CYC) |=> o_rate_err)
    else $error("slow frame not flagged");
endmodule

// ### testbench/vft_sink_model.sv
// receiver model of the video port that measures the source timing
module vft_sink_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_pclk,
  input wire logic i_frame_sync,
  input wire logic i_line_sync,
  input wire logic i_data_enable,
  input wire logic [vft_pkg::PIX_W-1:0] i_pixel_data,
  output logic [vft_pkg::HW-1:0] o_hsw,
  output logic [vft_pkg::HW-1:0] o_hbp,
  output logic [vft_pkg::HW-1:0] o_hact,
  output logic [vft_pkg::HW-1:0] o_htot,
  output logic [vft_pkg::VTW-1:0] o_vsw,
  output logic [vft_pkg::VTW-1:0] o_vbp,
  output logic [vft_pkg::VTW-1:0] o_vact,
  output logic [vft_pkg::VTW-1:0] o_vtot,
  output logic [7:0] o_frames,
  output logic [vft_pkg::PIX_W-1:0] o_pix17,
  output logic o_bad_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import vft_pkg::*;
  // ------------------------------
  // sampling of the pixel clock
  // ------------------------------
  logic pclk_r; // pixel clock seen last sys cycle
  logic ls_r; // line sync at the previous active edge
  logic fs_r; // frame sync at the previous line start
  logic de_r; // data enable at the previous active edge
  logic [HW-1:0] hcnt_r; // pixels since line start
  logic [HW-1:0] acnt_r; // active pixels in this line
  logic [VTW-1:0] lcnt_r; // line index within the frame
  logic [VTW-1:0] vcnt_r; // active lines so far
  logic act_edge; // pixel clock rising, the only sampling point
  logic line_go; // first pixel of a new line
  assign act_edge = i_pclk & ~pclk_r;
  assign line_go = act_edge & i_line_sync & ~ls_r;
  // horizontal figures, counted in pixel clocks
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pclk_r <= 1'b0;
      ls_r <= 1'b0;
      de_r <= 1'b0;
      o_bad_data <= 1'b0;
    end else begin
      pclk_r <= i_pclk;
      if (act_edge) begin
        ls_r <= i_line_sync;
        de_r <= i_data_enable;
        hcnt_r <= line_go ? H_ONE : hcnt_r + H_ONE;
        if (line_go) o_htot <= hcnt_r;
        if (!i_line_sync && ls_r) o_hsw <= hcnt_r;
        if (i_data_enable && !de_r) o_hbp <= hcnt_r;
        // count restarts on the enable rise and is read at its fall
        acnt_r <= (i_data_enable && !de_r) ? H_ONE : acnt_r + H_ONE;
        if (i_data_enable && de_r && acnt_r == 13'h0011) begin
          o_pix17 <= i_pixel_data;
        end
        if (!i_data_enable && de_r) o_hact <= acnt_r;
        // data outside enable would be taken for picture
        if (!i_data_enable && i_pixel_data != '0) o_bad_data <= 1'b1;
      end
    end
  end
  // vertical figures, counted in whole lines
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fs_r <= 1'b0;
      lcnt_r <= '0;
      vcnt_r <= '0;
      o_frames <= 8'h00;
    end else if (line_go) begin
      fs_r <= i_frame_sync;
      if (i_frame_sync && !fs_r) begin
        o_vtot <= lcnt_r + V_ONE;
        o_vact <= vcnt_r;
        lcnt_r <= '0;
        vcnt_r <= '0;
        o_frames <= o_frames + 8'h01;
      end else begin
        lcnt_r <= lcnt_r + V_ONE;
      end
      if (!i_frame_sync && fs_r) o_vsw <= lcnt_r + V_ONE;
    end else if (act_edge && i_data_enable && !de_r) begin
      if (vcnt_r == '0) o_vbp <= lcnt_r;
      vcnt_r <= vcnt_r + V_ONE;
    end
  end
endmodule

// ### testbench/vft_source_frame_timing_test.sv
// self-checking bench of the frame timing generator
module vft_source_frame_timing_test;
  timeunit 1ns;
  timeprecision 100ps;
  import vft_pkg::*;
  // ------------------------------
  // stimulus and observed signals
  // ------------------------------
  localparam int FMIN = 3500; // window around a 3600 cycle frame
  localparam int FMAX = 3700;
  localparam logic [PIX_W-1:0] COLOR = 24'h3c5a96;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic enable = 1'b0;
  logic [PW-1:0] h_sync = '0, h_back = '0, h_front = '0;
  logic [HW-1:0] h_active = '0;
  logic [VW-1:0] v_sync = '0, v_back = '0, v_front = '0, v_active = '0;
  vft_pat_e pattern = PAT_SOLID;
  logic pclk, frame_sync, line_sync, data_enable, busy, rate_err;
  logic bad_data;
  logic [PIX_W-1:0] pixel_data, pix17;
  logic [HW-1:0] hsw, hbp, hact, htot;
  logic [VTW-1:0] vsw, vbp, vact, vtot;
  logic [7:0] frames;
  int miscompares = 0;
  int checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  vft_source_top #(.FRAME_MIN_CYC(FMIN), .FRAME_MAX_CYC(FMAX),
    .PCLK_HALF(1)) vft_source_top_inst (.i_clk_sys(clk_sys),
    .i_rst_b(rst_b), .i_enable(enable), .i_h_sync(h_sync),
    .i_h_back(h_back), .i_h_front(h_front), .i_h_active(h_active),
    .i_v_sync(v_sync), .i_v_back(v_back), .i_v_front(v_front),
    .i_v_active(v_active), .i_pattern(pattern), .i_color(COLOR),
    .o_pclk(pclk), .o_frame_sync(frame_sync), .o_line_sync(line_sync),
    .o_data_enable(data_enable), .o_pixel_data(pixel_data),
    .o_busy(busy), .o_rate_err(rate_err));
  vft_sink_model vft_sink_model_inst (.i_clk_sys(clk_sys),
    .i_rst_b(rst_b), .i_pclk(pclk), .i_frame_sync(frame_sync),
    .i_line_sync(line_sync), .i_data_enable(data_enable),
    .i_pixel_data(pixel_data), .o_hsw(hsw), .o_hbp(hbp), .o_hact(hact),
    .o_htot(htot), .o_vsw(vsw), .o_vbp(vbp), .o_vact(vact),
    .o_vtot(vtot), .o_frames(frames), .o_pix17(pix17),
    .o_bad_data(bad_data));
  // ------------------------------
  // shared tasks
  // ------------------------------
  // inputs move 2 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic set_geo(input int hs, hb, hf, ha, vs, vb, vf, va);
    h_sync = PW'(hs);
    h_back = PW'(hb);
    h_front = PW'(hf);
    h_active = HW'(ha);
    v_sync = VW'(vs);
    v_back = VW'(vb);
    v_front = VW'(vf);
    v_active = VW'(va);
  endtask
  // bounded wait for a number of frame starts
  task automatic wait_frames(input int n);
    logic [7:0] f0;
    int k;
    f0 = frames;
    k = 0;
    while (8'(frames - f0) < 8'(n) && k < n * 5000) begin
      tick(1);
      k++;
    end
  endtask
  // expected geometry given as porches, totals worked out here
  task automatic check_geo(input int hs, hb, hf, ha, vs, vb, vf, va);
    cmp_val(32'(hsw), hs);
    cmp_val(32'(hbp), hb);
    cmp_val(32'(hact), ha);
    cmp_val(32'(htot), hb + ha + hf);
    cmp_val(32'(vsw), vs);
    cmp_val(32'(vbp), vb);
    cmp_val(32'(vact), va);
    cmp_val(32'(vtot), vb + va + vf);
    cmp_bit(bad_data, 1'b0);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic test_nominal();
    set_geo(10, 20, 50, 30, 2, 5, 10, 3);
    enable = 1'b1;
    wait_frames(3);
    check_geo(10, 20, 50, 30, 2, 5, 10, 3);
    cmp_bit(rate_err, 1'b0);
    cmp_val(32'(pix17), 32'(COLOR));
    $display("test nominal done");
  endtask
  // pixel 17 of line 2: checker square and ramps are told apart
  // the pattern moves just after a frame start, so one frame is enough
  task automatic test_patterns();
    logic [PIX_W-1:0] exp;
    for (int i = 1; i < 4; i++) begin
      pattern = vft_pat_e'(i);
      wait_frames(1);
      case (pattern)
        PAT_HRAMP: exp = {3{8'h11}};
        PAT_VRAMP: exp = {3{8'h02}};
        default: exp = COLOR;
      endcase
      cmp_val(32'(pix17), 32'(exp));
    end
    $display("test patterns done");
  endtask
  // too small a request must come out at the minimum figures
  task automatic test_clamp();
    set_geo(12, 3, 1, 20, 5, 0, 0, 1);
    wait_frames(4);
    check_geo(8, 9, 55, 20, 1, 2, 12, 1);
    cmp_bit(rate_err, 1'b1);
    $display("test clamp done");
  endtask
  // an oversized line is cut to the longest total, then reset mid-line
  task automatic test_long_line();
    int k;
    set_geo(8, 9, 55, 8191, 1, 2, 12, 1);
    wait_frames(1);
    k = 0;
    // the only active line is the third, so its width lands last
    while ((htot !== 13'h1fff || hact !== 13'h1fbf) && k < 60000) begin
      tick(1);
      k++;
    end
    cmp_val(32'(htot), 32'h00001fff);
    cmp_val(32'(hact), 32'h00001fbf);
    enable = 1'b0;
    rst_b = 1'b0;
    tick(1);
    cmp_val(32'({pclk, frame_sync, line_sync, data_enable, busy,
      rate_err, pixel_data}), 32'h00000000);
    rst_b = 1'b1;
    tick(2);
    $display("test long line done");
  endtask
  // a stop request lets the frame run out with its front porch
  task automatic test_stop();
    logic [7:0] f0;
    int k;
    // one more active line: 3800 cycles, a frame too slow for the window
    set_geo(10, 20, 50, 30, 2, 5, 10, 4);
    pattern = PAT_SOLID;
    enable = 1'b1;
    wait_frames(2);
    cmp_bit(rate_err, 1'b1);
    f0 = frames;
    enable = 1'b0;
    tick(20);
    cmp_bit(busy, 1'b1);
    k = 0;
    while (busy !== 1'b0 && k < 4000) begin
      tick(1);
      k++;
    end
    cmp_bit(busy, 1'b0);
    cmp_bit(k > 3400, 1'b1);
    cmp_val(32'(frames), 32'(f0));
    cmp_bit(line_sync | frame_sync | data_enable, 1'b0);
    $display("test stop done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------
  // main sequence and watchdog
  // ------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    test_nominal();
    test_patterns();
    test_clamp();
    test_long_line();
    test_stop();
    give_verdict();
  end
  // about 88k cycles expected, cut off near 104k
  initial begin
    #2_600_000;
    miscompares++;
    give_verdict();
  end
endmodule
